// ==== cmt_regs.vh ====
// constants for the card mode tracker
`ifndef CMT_REGS_VH
`define CMT_REGS_VH
`define CMT_ST_IDLE 4'h0
`define CMT_ST_READY 4'h1
`define CMT_ST_IDENT 4'h2
`define CMT_ST_STBY 4'h3
`define CMT_ST_TRAN 4'h4
`define CMT_ST_DATA 4'h5
`define CMT_ST_RCV 4'h6
`define CMT_ST_PRG 4'h7
`define CMT_ST_DIS 4'h8
`define CMT_RCA_RESET 16'h0000
`define CMT_CMD_GO_IDLE 6'h00
`define CMT_CMD_SEND_OP 6'h01
`define CMT_CMD_ALL_CID 6'h02
`define CMT_CMD_SET_RCA 6'h03
`define CMT_CMD_SELECT 6'h07
`define CMT_CMD_STOP 6'h0c
`define CMT_CMD_RD_SINGLE 6'h11
`define CMT_CMD_RD_MULTI 6'h12
`define CMT_CMD_WR_SINGLE 6'h18
`define CMT_CMD_WR_MULTI 6'h19
`define CMT_FRAME_BITS 6'h30
`endif

// ==== cmt_sync.v ====
// two-flop synchroniser with edge detect on the second stage output
`timescale 1ns/1ps
module cmt_sync
(
  input wire clock,
  input wire rst_n,
  input wire din,
  output reg dout,
  output reg rise
);
  reg meta;
  reg last;
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta <= 1'b1;
      dout <= 1'b1;
      last <= 1'b1;
      rise <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
      last <= dout;
      rise <= dout & ~last;
    end
  end
endmodule

// ==== cmt_card_mode_tracker.v ====
// card-side command receiver that tracks card state, mode and driver type
// What this block does
// - card only answers host commands, never initiates
// - go-idle accepted in every state; send-op only in idle, all-CID only in ready
// - select needs matching address to select, other addresses deselect only from tran and prg; read, write, stop ignore address
// - identification mode until set-address command
// - data transfer mode once address assigned
// - no interrupt mode built
// - idle, ready, ident: identification mode, open-drain
// - other states: transfer mode, push-pull drivers
// - bad CRC command discarded, state and address unchanged
// - ongoing operation continues past bad CRC
// - state held as four-bit binary code
// - reset or go-idle loads address zero
// - accepted address switches driver to push-pull
`timescale 1ns/1ps
`include "cmt_regs.vh"
module cmt_card_mode_tracker
(
  input wire clock,
  input wire rst_n,
  input wire bus_clk,
  input wire cmd_in,
  input wire [15:0] new_rca,
  input wire cid_won,
  input wire xfer_done,
  output reg [3:0] card_state,
  output reg [15:0] rca,
  output reg data_mode,
  output reg push_pull,
  output reg cmd_valid,
  output reg [5:0] cmd_index,
  output reg crc_error,
  output reg respond
);
  wire cmd_s;
  wire clk_rise;
  reg receiving;
  reg [5:0] bit_cnt;
  reg [47:0] shreg;
  reg [6:0] crc;
  reg [3:0] next_state;
  reg [15:0] next_rca;
  reg act;
  reg rsp;
  wire [47:0] frame;
  wire [5:0] idx;
  wire [15:0] arg_rca;
  wire crc_fb;
  wire addr_hit;

  // pin samples cross domains before use
  cmt_sync u_clk (.clock(clock), .rst_n(rst_n), .din(bus_clk), .dout(), .rise(clk_rise));
  cmt_sync u_cmd (.clock(clock), .rst_n(rst_n), .din(cmd_in), .dout(cmd_s), .rise());

  assign frame = {shreg[46:0], cmd_s};
  assign idx = frame[45:40];
  assign arg_rca = frame[39:24];
  assign addr_hit = (arg_rca == rca);
  // crc7 over bits 47..8, checked against the received field
  assign crc_fb = cmd_s ^ crc[6];

  // state transition on a good frame; bad frames are decoded here but never applied
  always @*
  begin
    next_state = card_state;
    next_rca = rca;
    act = 1'b0;
    rsp = 1'b0;
    if (idx == `CMT_CMD_GO_IDLE)
    begin
      next_state = `CMT_ST_IDLE;
      next_rca = `CMT_RCA_RESET;
      act = 1'b1;
    end
    else
    begin
      case (card_state)
        `CMT_ST_IDLE:
          if (idx == `CMT_CMD_SEND_OP)
          begin
            next_state = `CMT_ST_READY;
            act = 1'b1;
            rsp = 1'b1;
          end
        `CMT_ST_READY:
          if (idx == `CMT_CMD_ALL_CID)
          begin
            act = 1'b1;
            rsp = 1'b1;
            if (cid_won)
              next_state = `CMT_ST_IDENT;
          end
        `CMT_ST_IDENT:
          if (idx == `CMT_CMD_SET_RCA)
          begin
            next_state = `CMT_ST_STBY;
            next_rca = new_rca;
            act = 1'b1;
            rsp = 1'b1;
          end
        `CMT_ST_STBY:
          if (idx == `CMT_CMD_SELECT && addr_hit)
          begin
            next_state = `CMT_ST_TRAN;
            act = 1'b1;
            rsp = 1'b1;
          end
        `CMT_ST_TRAN:
          if (idx == `CMT_CMD_SELECT)
          begin
            act = 1'b1;
            rsp = addr_hit;
            if (!addr_hit)
              next_state = `CMT_ST_STBY;
          end
          else if (idx == `CMT_CMD_RD_SINGLE || idx == `CMT_CMD_RD_MULTI)
          begin
            next_state = `CMT_ST_DATA;
            act = 1'b1;
            rsp = 1'b1;
          end
          else if (idx == `CMT_CMD_WR_SINGLE || idx == `CMT_CMD_WR_MULTI)
          begin
            next_state = `CMT_ST_RCV;
            act = 1'b1;
            rsp = 1'b1;
          end
        `CMT_ST_DATA, `CMT_ST_RCV:
          if (idx == `CMT_CMD_STOP)
          begin
            next_state = (card_state == `CMT_ST_RCV) ? `CMT_ST_PRG : `CMT_ST_TRAN;
            act = 1'b1;
            rsp = 1'b1;
          end
        `CMT_ST_PRG:
          if (idx == `CMT_CMD_SELECT && !addr_hit)
          begin
            next_state = `CMT_ST_DIS;
            act = 1'b1;
          end
        `CMT_ST_DIS:
          if (idx == `CMT_CMD_SELECT && addr_hit)
          begin
            next_state = `CMT_ST_PRG;
            act = 1'b1;
            rsp = 1'b1;
          end
        default:
          next_state = `CMT_ST_IDLE;
      endcase
    end
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      receiving <= 1'b0;
      bit_cnt <= 6'h00;
      shreg <= 48'h000000000000;
      crc <= 7'h00;
      card_state <= `CMT_ST_IDLE;
      rca <= `CMT_RCA_RESET;
      data_mode <= 1'b0;
      push_pull <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_index <= 6'h00;
      crc_error <= 1'b0;
      respond <= 1'b0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      crc_error <= 1'b0;
      respond <= 1'b0;
      if (clk_rise)
      begin
        // mode follows the registered state only at bus-clock edges
        data_mode <= (card_state >= `CMT_ST_STBY) && (card_state <= `CMT_ST_DIS);
        push_pull <= (card_state >= `CMT_ST_STBY) && (card_state <= `CMT_ST_DIS);
        if (xfer_done && (card_state == `CMT_ST_PRG))
          card_state <= `CMT_ST_TRAN;
        else if (xfer_done && (card_state == `CMT_ST_DIS))
          card_state <= `CMT_ST_STBY;
        if (!receiving)
        begin
          // start bit begins a host frame; the card never starts one itself
          if (!cmd_s)
          begin
            receiving <= 1'b1;
            bit_cnt <= 6'h01;
            shreg <= 48'h000000000000;
            crc <= {6'h00, 1'b0};
          end
        end
        else
        begin
          shreg <= frame;
          bit_cnt <= bit_cnt + 6'h01;
          if (bit_cnt < 6'h28)
            crc <= {crc[5:3], crc[2] ^ crc_fb, crc[1:0], crc_fb};
          if (bit_cnt == `CMT_FRAME_BITS - 6'h01)
          begin
            receiving <= 1'b0;
            cmd_index <= idx;
            if (frame[46] && frame[0] && (frame[7:1] == crc))
            begin
              cmd_valid <= act;
              respond <= rsp;
              card_state <= next_state;
              rca <= next_rca;
            end
            else
              crc_error <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ==== cmt_sva.sv ====
// checker on the card mode tracker ports
`timescale 1ns/1ps
`include "cmt_regs.vh"
module cmt_sva
(
  input wire clock,
  input wire rst_n,
  input wire [3:0] card_state,
  input wire [15:0] rca,
  input wire data_mode,
  input wire push_pull,
  input wire cmd_valid,
  input wire [5:0] cmd_index,
  input wire crc_error,
  input wire respond
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_code; card_state <= `CMT_ST_DIS; endproperty
  a_code: assert property (p_code) else $error("state code out of range");
  property p_drv; push_pull == data_mode; endproperty
  a_drv: assert property (p_drv) else $error("driver type and mode differ");
  property p_drv_src; $changed(push_pull) |->
    push_pull == ($past(card_state) >= `CMT_ST_STBY && $past(card_state) <= `CMT_ST_DIS); endproperty
  a_drv_src: assert property (p_drv_src) else $error("driver type off registered state");
  property p_up; $rose(data_mode) |-> card_state == `CMT_ST_STBY; endproperty
  a_up: assert property (p_up) else $error("transfer mode off standby");
  property p_down; $fell(data_mode) |-> card_state == `CMT_ST_IDLE; endproperty
  a_down: assert property (p_down) else $error("ident mode off idle");
  property p_bad; crc_error |-> $stable(card_state) && $stable(rca) && !cmd_valid; endproperty
  a_bad: assert property (p_bad) else $error("bad frame was acted on");
  property p_resp; respond |-> cmd_valid; endproperty
  a_resp: assert property (p_resp) else $error("answer without command");
  property p_zero; cmd_valid && cmd_index == `CMT_CMD_GO_IDLE |->
    ##[0:1] rca == `CMT_RCA_RESET && card_state == `CMT_ST_IDLE; endproperty
  a_zero: assert property (p_zero) else $error("go idle left address");
  property p_set; cmd_valid && cmd_index == `CMT_CMD_SET_RCA |->
    ##[0:1] card_state == `CMT_ST_STBY; endproperty
  a_set: assert property (p_set) else $error("set address not standby");
endmodule
bind cmt_card_mode_tracker cmt_sva u_cmt_sva (.*);

// ==== cmt_host_model.sv ====
// host model driving the bus clock and command frames
`timescale 1ns/1ps
module cmt_host_model
(
  output reg bus_clk,
  output reg cmd_in
);
  initial
  begin
    bus_clk = 1'b0;
    cmd_in = 1'b1;
  end
  function [6:0] crc7(input [39:0] d);
    integer i;
    begin
      crc7 = 7'h00;
      for (i = 39; i >= 0; i = i - 1)
        crc7 = {crc7[5:0], d[i] ^ crc7[6]} ^ {3'h0, d[i] ^ crc7[6], 3'h0};
    end
  endfunction
  // clock stands low between frames; four idle rises let the mode settle
  task send(input [5:0] idx, input [31:0] arg, input bad);
    reg [47:0] f;
    integer i;
    begin
      f = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad}, 1'b1};
      for (i = 47; i >= -4; i = i - 1)
      begin
        cmd_in = (i >= 0) ? f[i] : 1'b1;
        #62.5 bus_clk = 1'b1;
        #62.5 bus_clk = 1'b0;
      end
    end
  endtask
endmodule

// ==== test_card_mode_tracker.sv ====
// self-checking bench for the card mode tracker
`timescale 1ns/1ps
`include "cmt_regs.vh"
module test_card_mode_tracker;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg cid_won = 1'b0;
  reg xfer_done = 1'b0;
  reg [15:0] new_rca = 16'h0000;
  reg [15:0] val;
  reg [5:0] ix;
  reg [13:0] row [0:15];
  wire bus_clk, cmd_in, data_mode, push_pull, cmd_valid, crc_error, respond;
  wire [3:0] card_state;
  wire [5:0] cmd_index;
  wire [15:0] rca;
  integer err_total = 0, checked = 0, nv = 0, ne = 0, nr = 0;
  integer t, v0, e0, r0;
  cmt_host_model u_cmt_host_model (.bus_clk(bus_clk), .cmd_in(cmd_in));
  cmt_card_mode_tracker u_cmt_card_mode_tracker (.clock(clock), .rst_n(rst_n),
    .bus_clk(bus_clk), .cmd_in(cmd_in), .new_rca(new_rca), .cid_won(cid_won),
    .xfer_done(xfer_done), .card_state(card_state), .rca(rca), .data_mode(data_mode),
    .push_pull(push_pull), .cmd_valid(cmd_valid), .cmd_index(cmd_index),
    .crc_error(crc_error), .respond(respond));
  initial forever #5 clock = ~clock;
  // pulses last one cycle, so they are counted rather than sampled
  // cleared in reset so unknown outputs before the first edge never reach the counts
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      nv <= 0;
      ne <= 0;
      nr <= 0;
    end
    else
    begin
      nv <= nv + cmd_valid;
      ne <= ne + crc_error;
      nr <= nr + respond;
    end
  end
  function [15:0] exp_rca(input [3:0] s);
    exp_rca = (s > `CMT_ST_IDENT) ? val : `CMT_RCA_RESET;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  initial
  begin
    #400000;
    err_total = err_total + 1;
    tally_and_finish;
  end
  initial
  begin
    // done, acts, index, wrong address, bad check, state after; cards identified first
    row = '{14'h1000, 14'h1041, 14'h1082, 14'h00d2, 14'h10c3, 14'h01e3, 14'h11c4, 14'h1485,
      14'h0315, 14'h1304, 14'h1606, 14'h1307, 14'h11e8, 14'h31c4, 14'h11e3, 14'h1000};
    v0 = $urandom(32177);
    val = {1'b0, 14'($urandom), 1'b1};
    repeat (12) @(posedge clock);
    #1 rst_n = 1'b1;
    new_rca = val;
    cid_won = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    for (t = 0; t < 16; t = t + 1)
    begin
      @(posedge clock);
      #1;
      xfer_done = row[t][13];
      ix = row[t][11:6];
      // single and multi variants picked at random; both lead to the same state
      if (ix == `CMT_CMD_RD_MULTI && $urandom_range(1))
        ix = `CMT_CMD_RD_SINGLE;
      if (ix == `CMT_CMD_WR_SINGLE && $urandom_range(1))
        ix = `CMT_CMD_WR_MULTI;
      v0 = nv;
      e0 = ne;
      r0 = nr;
      u_cmt_host_model.send(ix, {row[t][5] ? ~val : val, 16'h0000}, row[t][4]);
      chk({28'h0, card_state}, {28'h0, row[t][3:0]});
      chk({30'h0, push_pull, data_mode}, {30'h0, {2{row[t][3:0] > 4'h2}}});
      chk({16'h0, rca}, {16'h0, exp_rca(row[t][3:0])});
      chk(ne - e0, row[t][4]);
      chk({26'h0, cmd_index}, {26'h0, ix});
      chk(nv - v0, row[t][12]);
      chk(nr - r0, row[t][12] && !row[t][5] && ix != `CMT_CMD_GO_IDLE);
      $display("test %0d end", t);
    end
    tally_and_finish;
  end
endmodule
